/* File: logic/irq_seq_map.svh */
// Constants for the vectored interrupt sequencer: register offsets,
// field positions, reset values, vectors and timing counts.
// Assumes inclusion by bare name from logic/ files only.
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH

// Program counter geometry
`define PC_WIDTH 12
`define PC_OFFSET_WIDTH 7
`define PAGE_WORDS 128
`define WORD_BITS 10
`define VECTOR_PAGE 5'h01

// Vector offsets inside the vector page
`define VEC_EXT 7'h00
`define VEC_TIMER_ONE 7'h04
`define VEC_TIMER_TWO 7'h06
`define VEC_CONVERTER 7'h0C

// Source indices, also the priority order (0 highest)
`define SRC_EXT 2'h0
`define SRC_TIMER_ONE 2'h1
`define SRC_TIMER_TWO 2'h2
`define SRC_CONVERTER 2'h3

// APB register byte offsets
`define OFF_IRQ_CTRL1 8'h00
`define OFF_IRQ_CTRL2 8'h04
`define OFF_STATUS 8'h08
`define OFF_PC 8'h0C

// Enable bit positions
`define BIT_EXT_EN 0
`define BIT_TIMER_ONE_EN 2
`define BIT_TIMER_TWO_EN 3
`define BIT_CONVERTER_EN 2

// Status field positions
`define STATUS_GIE_BIT 4
`define STATUS_ENABLE_PEND_BIT 5

// Reset values
`define CTRL1_RESET 4'h0
`define CTRL2_RESET 4'h0
`define PC_RESET 12'h000

// Extra wait cycles when the condition meets a multi-cycle instruction
`define MULTI_EXTRA_CYCLES 1

`endif

/* File: logic/irq_seq_pkg.sv */
// Types shared by the vectored interrupt sequencer files.
// Assumes irq_seq_map.svh is on the include path.
`include "irq_seq_map.svh"

package irq_seq_pkg;

  typedef enum logic [2:0] {
    KIND_SEQ = 3'h0,
    KIND_JUMP = 3'h1,
    KIND_ENABLE_IRQ = 3'h2,
    KIND_DISABLE_IRQ = 3'h3,
    KIND_RETURN_IRQ = 3'h4,
    KIND_SKIPTEST = 3'h5
  } instr_kind_e;

  typedef struct packed {
    instr_kind_e kind;
    logic [1:0] src;
    logic [1:0] words;
    logic [`PC_WIDTH-1:0] target;
  } instr_s;

  typedef struct packed {
    logic [8:0] ram_pointer;
    logic carry_bit;
    logic skip;
    logic [3:0] reg_a;
    logic [3:0] reg_b;
  } ctx_s;

  typedef struct packed {
    logic [`PC_WIDTH-1:`PC_OFFSET_WIDTH] pc_page_field;
    logic [`PC_OFFSET_WIDTH-1:0] pc_offset_field;
  } pc_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARM = 2'h1,
    ST_HOLD = 2'h3,
    ST_TAKEN = 2'h2
  } take_state_e;

endpackage

/* File: logic/paged_pc.sv */
// Paged program counter: page field above, in-page offset below.
// Assumes the caller gives either a load or a step each cycle, not both.
`timescale 1ns/1ps
`include "irq_seq_map.svh"
module paged_pc #(
  parameter int PC_W = `PC_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [PC_W-1:0] load_addr,
  input wire logic [1:0] step,
  output logic [PC_W-1:0] pc_q
);

  if (PC_W <= `PC_OFFSET_WIDTH) begin : g_bad_width
    $error("paged_pc: counter must be wider than the offset field");
  end

  // Plain binary add carries offset 127 into the next page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_W'(`PC_RESET);
    end else if (load) begin
      pc_q <= load_addr;
    end else begin
      pc_q <= pc_q + PC_W'(step);
    end
  end

endmodule

/* File: logic/request_flag.sv */
// One latched interrupt request flag.
// Assumes set and clear are single-cycle pulses on pclk.
`timescale 1ns/1ps
module request_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set_pulse) begin
      // A new event beats a clear in the same cycle
      flag_q <= 1'b1;
    end else if (clr_pulse) begin
      flag_q <= 1'b0;
    end
  end

endmodule

/* File: logic/vectored_interrupt_sequencer.sv */
// Vectored interrupt sequencer with its paged program counter and APB
// register window. Assumes the instruction sequencer reports each retired
// instruction as a one-cycle pulse and stalls while irq_take is high.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "irq_seq_map.svh"
module vectored_interrupt_sequencer #(
  parameter int PC_W = `PC_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] source_event,
  input wire logic instr_valid,
  input wire irq_seq_pkg::instr_s instr,
  input wire logic multi_cycle_busy,
  input wire irq_seq_pkg::ctx_s ctx_live,
  output irq_seq_pkg::pc_s pc,
  output logic irq_take,
  output logic [1:0] irq_source,
  output logic ret_push,
  output logic [PC_W-1:0] ret_addr,
  output logic ret_pop,
  output logic ctx_restore_valid,
  output irq_seq_pkg::ctx_s ctx_restore,
  output logic skip_next,
  output logic [3:0] request_flags,
  output logic global_irq_enable
);

  if (PC_W != `PC_WIDTH) begin : g_bad_pc
    $error("vectored_interrupt_sequencer: PC_W must match the pc_s type");
  end

  logic [3:0] ctrl1_q;
  logic [3:0] ctrl2_q;
  logic [3:0] flags;
  logic [3:0] enables;
  logic [3:0] pending;
  logic [3:0] clr_take;
  logic [3:0] clr_skip;
  logic gie_q;
  logic enable_pend_q;
  logic take_now;
  logic [1:0] take_src;
  logic [PC_W-1:0] seq_next;
  logic [PC_W-1:0] vector_addr;
  logic [PC_W-1:0] pc_addr;
  logic pc_load;
  logic [PC_W-1:0] pc_load_addr;
  logic [1:0] pc_step;
  logic skip_hit;
  irq_seq_pkg::ctx_s ctx_store_q;
  irq_seq_pkg::take_state_e state_q;
  irq_seq_pkg::take_state_e state_d;

  assign enables = {ctrl1_q[`BIT_TIMER_TWO_EN], ctrl1_q[`BIT_TIMER_ONE_EN],
                    ctrl1_q[`BIT_EXT_EN], ctrl2_q[`BIT_CONVERTER_EN]} == 4'h0 ? 4'h0 :
                   {ctrl2_q[`BIT_CONVERTER_EN], ctrl1_q[`BIT_TIMER_TWO_EN],
                    ctrl1_q[`BIT_TIMER_ONE_EN], ctrl1_q[`BIT_EXT_EN]};

  assign pending = gie_q ? (flags & enables) : 4'h0;

  function automatic logic [1:0] pick(input logic [3:0] p);
    logic [1:0] s;
    s = `SRC_CONVERTER;
    if (p[2]) begin
      s = `SRC_TIMER_TWO;
    end
    if (p[1]) begin
      s = `SRC_TIMER_ONE;
    end
    if (p[0]) begin
      s = `SRC_EXT;
    end
    return s;
  endfunction

  assign take_src = pick(pending);
  assign take_now = ((state_q == irq_seq_pkg::ST_ARM && !multi_cycle_busy) ||
                     state_q == irq_seq_pkg::ST_HOLD) && (pending != 4'h0);

  always_comb begin
    case (take_src)
      `SRC_EXT: vector_addr = {PC_W'(`VECTOR_PAGE)} << `PC_OFFSET_WIDTH | PC_W'(`VEC_EXT);
      `SRC_TIMER_ONE: vector_addr = {PC_W'(`VECTOR_PAGE)} << `PC_OFFSET_WIDTH | PC_W'(`VEC_TIMER_ONE);
      `SRC_TIMER_TWO: vector_addr = {PC_W'(`VECTOR_PAGE)} << `PC_OFFSET_WIDTH | PC_W'(`VEC_TIMER_TWO);
      default: vector_addr = {PC_W'(`VECTOR_PAGE)} << `PC_OFFSET_WIDTH | PC_W'(`VEC_CONVERTER);
    endcase
  end

  // Skip test works only with the enable bit clear
  assign skip_hit = instr_valid && instr.kind == irq_seq_pkg::KIND_SKIPTEST &&
                    flags[instr.src] && !enables[instr.src];

  // Clear only the serviced flag or the skipped one
  always_comb begin
    clr_take = 4'h0;
    clr_skip = 4'h0;
    if (take_now) begin
      clr_take[take_src] = 1'b1;
    end
    if (skip_hit) begin
      clr_skip[instr.src] = 1'b1;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_flag
    request_flag u_flag (
      .pclk(pclk),
      .presetn(presetn),
      .set_pulse(source_event[i]),
      .clr_pulse(clr_take[i] | clr_skip[i]),
      .flag_q(flags[i])
    );
  end

  // Where the retiring instruction leaves the counter
  always_comb begin
    seq_next = pc_addr;
    if (instr_valid) begin
      if (instr.kind == irq_seq_pkg::KIND_JUMP || instr.kind == irq_seq_pkg::KIND_RETURN_IRQ) begin
        seq_next = instr.target;
      end else begin
        seq_next = pc_addr + PC_W'(instr.words);
      end
    end
  end

  // Jump and return load instr.target; a take overrides
  always_comb begin
    pc_load = 1'b0;
    pc_load_addr = instr.target;
    pc_step = 2'h0;
    if (take_now) begin
      pc_load = 1'b1;
      pc_load_addr = vector_addr;
    end else if (instr_valid) begin
      if (instr.kind == irq_seq_pkg::KIND_JUMP || instr.kind == irq_seq_pkg::KIND_RETURN_IRQ) begin
        pc_load = 1'b1;
      end else begin
        pc_step = instr.words;
      end
    end
  end

  // Paged counter, binary carry across pages
  paged_pc #(
    .PC_W(PC_W)
  ) u_pc (
    .pclk(pclk),
    .presetn(presetn),
    .load(pc_load),
    .load_addr(pc_load_addr),
    .step(pc_step),
    .pc_q(pc_addr)
  );

  assign pc = irq_seq_pkg::pc_s'(pc_addr);

  // Two cycles normally, one more inside a multi-cycle instruction
  always_comb begin
    state_d = state_q;
    case (state_q)
      irq_seq_pkg::ST_IDLE: begin
        if (pending != 4'h0) begin
          state_d = irq_seq_pkg::ST_ARM;
        end
      end
      irq_seq_pkg::ST_ARM: begin
        if (pending == 4'h0) begin
          state_d = irq_seq_pkg::ST_IDLE;
        end else if (multi_cycle_busy) begin
          state_d = irq_seq_pkg::ST_HOLD;
        end else begin
          state_d = irq_seq_pkg::ST_TAKEN;
        end
      end
      irq_seq_pkg::ST_HOLD: begin
        state_d = take_now ? irq_seq_pkg::ST_TAKEN : irq_seq_pkg::ST_IDLE;
      end
      irq_seq_pkg::ST_TAKEN: begin
        state_d = irq_seq_pkg::ST_IDLE;
      end
      default: begin
        state_d = irq_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= irq_seq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Global enable and delayed enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_q <= 1'b0;
      enable_pend_q <= 1'b0;
    end else if (take_now) begin
      gie_q <= 1'b0;
      enable_pend_q <= 1'b0;
    end else if (instr_valid) begin
      case (instr.kind)
        irq_seq_pkg::KIND_ENABLE_IRQ: begin
          // Armed now, effective after the next instruction
          enable_pend_q <= 1'b1;
        end
        irq_seq_pkg::KIND_DISABLE_IRQ: begin
          gie_q <= 1'b0;
          enable_pend_q <= 1'b0;
        end
        default: begin
          if (enable_pend_q) begin
            gie_q <= 1'b1;
            enable_pend_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Take: push return address, one-stage context save
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_take <= 1'b0;
      irq_source <= 2'h0;
      ret_push <= 1'b0;
      ret_addr <= '0;
      ctx_store_q <= '0;
    end else begin
      irq_take <= take_now;
      ret_push <= take_now;
      if (take_now) begin
        irq_source <= take_src;
        ret_addr <= seq_next;
        ctx_store_q <= ctx_live;
      end
    end
  end

  // Return restores context and pops the stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_pop <= 1'b0;
      ctx_restore_valid <= 1'b0;
      ctx_restore <= '0;
    end else begin
      ret_pop <= instr_valid && instr.kind == irq_seq_pkg::KIND_RETURN_IRQ && !take_now;
      ctx_restore_valid <= instr_valid && instr.kind == irq_seq_pkg::KIND_RETURN_IRQ && !take_now;
      ctx_restore <= ctx_store_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_next <= 1'b0;
    end else begin
      skip_next <= skip_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_flags <= 4'h0;
      global_irq_enable <= 1'b0;
    end else begin
      request_flags <= flags;
      global_irq_enable <= gie_q;
    end
  end

  // APB slave: decode in setup, answer with pready in the first access cycle
  logic apb_setup;
  logic apb_write;
  logic apb_known;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && pready;
  assign apb_known = paddr == `OFF_IRQ_CTRL1 || paddr == `OFF_IRQ_CTRL2 ||
                     paddr == `OFF_STATUS || paddr == `OFF_PC;

  // Control registers reset to zero; writes land at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= `CTRL1_RESET;
      ctrl2_q <= `CTRL2_RESET;
    end else if (apb_write && !pslverr) begin
      if (paddr == `OFF_IRQ_CTRL1) begin
        ctrl1_q <= pwdata[3:0];
      end
      if (paddr == `OFF_IRQ_CTRL2) begin
        ctrl2_q <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !apb_known;
      prdata <= 32'h0000_0000;
      if (apb_setup && !pwrite) begin
        case (paddr)
          `OFF_IRQ_CTRL1: prdata <= {28'h000_0000, ctrl1_q};
          `OFF_IRQ_CTRL2: prdata <= {28'h000_0000, ctrl2_q};
          `OFF_STATUS: prdata <= {26'h000_0000, enable_pend_q, gie_q, flags};
          `OFF_PC: prdata <= 32'(pc_addr);
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: tb/irq_seq_sva.sv */
// Concurrent checks on the sequencer's top-level ports.
// Assumes binding into vectored_interrupt_sequencer.
`timescale 1ns/1ps
module irq_seq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_valid,
  input wire irq_seq_pkg::instr_s instr,
  input wire irq_seq_pkg::pc_s pc,
  input wire logic irq_take,
  input wire logic [1:0] irq_source,
  input wire logic ret_push,
  input wire logic ret_pop,
  input wire logic ctx_restore_valid,
  input wire logic [3:0] request_flags,
  input wire logic global_irq_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] vec_w;
  assign vec_w = (irq_source == 2'h0) ? 12'h080 : (irq_source == 2'h1) ? 12'h084 :
                 (irq_source == 2'h2) ? 12'h086 : 12'h08C;
  a_take_push: assert property (irq_take |-> ret_push)
    else $error("no return push on take");
  a_vector_load: assert property (irq_take |-> pc == vec_w)
    else $error("wrong vector on take");
  a_gie_cleared: assert property (irq_take |-> ##[0:2] !global_irq_enable)
    else $error("global enable kept after take");
  a_flag_cleared: assert property (irq_take |-> ##2 !request_flags[irq_source])
    else $error("serviced flag not cleared");
  a_rti_resume: assert property (instr_valid && instr.kind == irq_seq_pkg::KIND_RETURN_IRQ |=>
    irq_take || pc == $past(instr.target))
    else $error("return did not resume");
  a_rti_restore: assert property (instr_valid && instr.kind == irq_seq_pkg::KIND_RETURN_IRQ |=>
    ret_pop && ctx_restore_valid)
    else $error("no restore after return");
  a_jump_load: assert property (instr_valid && instr.kind == irq_seq_pkg::KIND_JUMP |=>
    irq_take || pc == $past(instr.target))
    else $error("jump did not load counter");
  a_di_clears: assert property (instr_valid && instr.kind == irq_seq_pkg::KIND_DISABLE_IRQ |->
    ##[1:2] !global_irq_enable)
    else $error("disable left global enable set");
  a_page_wrap: assert property (instr_valid && instr.kind == irq_seq_pkg::KIND_SEQ && instr.words == 2'h1 &&
    pc.pc_offset_field == 7'h7F && request_flags == 4'h0 |=>
    pc.pc_offset_field == 7'h00 && pc.pc_page_field == $past(pc.pc_page_field) + 5'h01)
    else $error("page wrap wrong");
endmodule

bind vectored_interrupt_sequencer irq_seq_sva irq_seq_sva_inst (.pclk(pclk), .presetn(presetn),
  .instr_valid(instr_valid), .instr(instr), .pc(pc), .irq_take(irq_take), .irq_source(irq_source),
  .ret_push(ret_push), .ret_pop(ret_pop), .ctx_restore_valid(ctx_restore_valid),
  .request_flags(request_flags), .global_irq_enable(global_irq_enable));

/* File: tb/seq_model.sv */
// Instruction sequencer and request sources in front of the block.
// Assumes the caller sequences takes and retires apart.
`timescale 1ns/1ps
module seq_model (
  input wire logic pclk,
  input wire logic irq_take,
  output logic instr_valid,
  output irq_seq_pkg::instr_s instr,
  output logic [3:0] source_event
);
  initial begin
    instr_valid = 1'b0;
    instr = '0;
    source_event = 4'h0;
  end
  task automatic fire(input logic [3:0] m);
    @(posedge pclk);
    source_event <= m;
    @(posedge pclk);
    source_event <= 4'h0;
  endtask
  task automatic retire(input irq_seq_pkg::instr_kind_e k, input logic [1:0] s, input logic [11:0] t);
    @(posedge pclk);
    // Sequencer stalls while a take is shown
    while (irq_take === 1'b1) @(posedge pclk);
    instr_valid <= 1'b1;
    instr <= '{kind: k, src: s, words: 2'h1, target: t};
    @(posedge pclk);
    instr_valid <= 1'b0;
  endtask
endmodule

/* File: tb/tb_vectored_interrupt_sequencer.sv */
// Self-checking bench for the vectored interrupt sequencer.
// Assumes seq_model stands in for the sequencer and sources.
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_vectored_interrupt_sequencer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, instr_valid, irq_take, ret_push, ret_pop, ctx_restore_valid, skip_next, global_irq_enable;
  logic [3:0] source_event, request_flags, exp_f;
  irq_seq_pkg::instr_s instr;
  logic multi_cycle_busy = 1'b0;
  irq_seq_pkg::ctx_s ctx_live = '0;
  irq_seq_pkg::ctx_s ctx_val, ctx_restore;
  irq_seq_pkg::pc_s pc;
  logic [1:0] irq_source;
  logic [11:0] ret_addr;
  logic [11:0] vec [4] = '{12'h080, 12'h084, 12'h086, 12'h08C};
  int num_checks = 0;
  int bad_count = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  vectored_interrupt_sequencer vectored_interrupt_sequencer_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .source_event(source_event), .instr_valid(instr_valid), .instr(instr),
    .multi_cycle_busy(multi_cycle_busy), .ctx_live(ctx_live), .pc(pc), .irq_take(irq_take),
    .irq_source(irq_source), .ret_push(ret_push), .ret_addr(ret_addr), .ret_pop(ret_pop),
    .ctx_restore_valid(ctx_restore_valid), .ctx_restore(ctx_restore), .skip_next(skip_next),
    .request_flags(request_flags), .global_irq_enable(global_irq_enable));
  seq_model seq_model_inst (.pclk(pclk), .irq_take(irq_take), .instr_valid(instr_valid), .instr(instr),
    .source_event(source_event));
  task automatic results();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, v, d, e);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] ev, input logic ee);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    `CHK("prdata", ev, d)
    `CHK("pslverr", ee, e)
  endtask
  // Edges counted until the take pulse is seen
  task automatic wait_take(output int n);
    n = 0;
    while (irq_take !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        bad_count++;
        results();
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(8'h00, 32'h0, 1'b0);
    chk_rd(8'h04, 32'h0, 1'b0);
    chk_rd(8'h10, 32'h0, 1'b1);
    wr(8'h00, 32'h0000000D);
    wr(8'h04, 32'h00000004);
    chk_rd(8'h00, 32'h0000000D, 1'b0);
    seq_model_inst.fire(4'hF);
    chk_rd(8'h08, 32'h0000000F, 1'b0);
    // Sources in turn, highest pending first
    for (int i = 0; i < 4; i++) begin
      ctx_val = irq_seq_pkg::ctx_s'(19'h1A5C3 + 19'(i));
      ctx_live <= ctx_val;
      seq_model_inst.retire(irq_seq_pkg::KIND_ENABLE_IRQ, 2'h0, 12'h000);
      repeat (2) @(posedge pclk);
      `CHK("gie", 1'b0, global_irq_enable)
      seq_model_inst.retire(irq_seq_pkg::KIND_SEQ, 2'h0, 12'h000);
      wait_take(cyc);
      // Conditions hold one cycle after the retire; take two cycles later
      `CHK("delay", 3, cyc)
      `CHK("pc", vec[i], pc)
      `CHK("ret_addr", (i == 0) ? 12'h002 : 12'h125, ret_addr)
      ctx_live <= ~ctx_val;
      exp_f = 4'hF << (i + 1);
      repeat (2) @(posedge pclk);
      `CHK("flags", exp_f, request_flags)
      `CHK("gie", 1'b0, global_irq_enable)
      seq_model_inst.retire(irq_seq_pkg::KIND_RETURN_IRQ, 2'h0, 12'h123);
      @(posedge pclk);
      `CHK("ctx", ctx_val, ctx_restore)
      `CHK("pc", 12'h123, pc)
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    seq_model_inst.fire(4'h2);
    seq_model_inst.retire(irq_seq_pkg::KIND_SKIPTEST, 2'h1, 12'h000);
    @(posedge pclk);
    `CHK("skip", 1'b1, skip_next)
    repeat (2) @(posedge pclk);
    `CHK("flags", 4'h0, request_flags)
    seq_model_inst.retire(irq_seq_pkg::KIND_JUMP, 2'h0, 12'h07F);
    seq_model_inst.retire(irq_seq_pkg::KIND_SEQ, 2'h0, 12'h000);
    @(posedge pclk);
    `CHK("pc", 12'h080, pc)
    wr(8'h00, 32'h4);
    seq_model_inst.fire(4'h2);
    seq_model_inst.retire(irq_seq_pkg::KIND_SKIPTEST, 2'h1, 12'h000);
    @(posedge pclk);
    `CHK("skip", 1'b0, skip_next)
    `CHK("flags", 4'h2, request_flags)
    // Multi-cycle instruction in flight: one extra cycle before the take
    multi_cycle_busy <= 1'b1;
    seq_model_inst.retire(irq_seq_pkg::KIND_ENABLE_IRQ, 2'h0, 12'h000);
    seq_model_inst.retire(irq_seq_pkg::KIND_SEQ, 2'h0, 12'h000);
    wait_take(cyc);
    `CHK("delay", 4, cyc)
    `CHK("pc", vec[1], pc)
    multi_cycle_busy <= 1'b0;
    // Flag pending with its enable clear: global enable alone must not take
    seq_model_inst.fire(4'h1);
    seq_model_inst.retire(irq_seq_pkg::KIND_ENABLE_IRQ, 2'h0, 12'h000);
    seq_model_inst.retire(irq_seq_pkg::KIND_SEQ, 2'h0, 12'h000);
    repeat (4) @(posedge pclk);
    `CHK("gie", 1'b1, global_irq_enable)
    `CHK("flags", 4'h1, request_flags)
    `CHK("take", 1'b0, irq_take)
    seq_model_inst.retire(irq_seq_pkg::KIND_DISABLE_IRQ, 2'h0, 12'h000);
    repeat (4) @(posedge pclk);
    `CHK("gie", 1'b0, global_irq_enable)
    `CHK("take", 1'b0, irq_take)
    results();
  end
endmodule
